// ==== verilog/pcel_pkg.sv ====
package pcel_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned US_NS         = 1000;
  localparam int unsigned US_CYCLES     = US_NS / CLK_PERIOD_NS;
  localparam int unsigned GATE_US       = 1000000;

  // widths
  localparam int RAW_W   = 16;
  localparam int VAL_W   = 12;
  localparam int CNT_W   = 32;
  localparam int SET_W   = 8;
  localparam int CODE_W  = 4;
  localparam int LPR_W   = 16;
  localparam int CPR_W   = 18;

  // pulse mode codes
  localparam logic [1:0] PMODE_OFF    = 2'h0;
  localparam logic [1:0] PMODE_WIDTH  = 2'h1;
  localparam logic [1:0] PMODE_FREQ   = 2'h2;
  localparam logic [1:0] PMODE_PERIOD = 2'h3;

  // encoder usage base codes
  localparam logic [CODE_W-1:0] EUSE_UNUSED   = 4'h0;
  localparam logic [CODE_W-1:0] EUSE_COMMAND  = 4'h1;
  localparam logic [CODE_W-1:0] EUSE_FEEDBACK = 4'h2;

  // action / usage setting layout: base code + motor1 weight 16 + motor2 weight 32
  localparam int SET_MOT1_BIT = 4;
  localparam int SET_MOT2_BIT = 5;
  localparam logic [CODE_W-1:0] ACT_NONE = 4'h0;

  // value ranges
  localparam logic [RAW_W-1:0]        RAW_MAX     = 16'hFDE8;
  localparam logic signed [VAL_W-1:0] VAL_HI      = 12'sh3E8;
  localparam logic signed [VAL_W-1:0] VAL_LO      = -12'sh3E8;
  localparam logic signed [31:0]      VAL_SPAN    = 32'sh0000_07D0;
  localparam logic [LPR_W-1:0]        LPR_MIN     = 16'h0001;
  localparam logic [LPR_W-1:0]        LPR_MAX     = 16'h1388;
  localparam int                      COUNTS_LINE = 4;

  // documented defaults for the settings ports
  localparam logic [RAW_W-1:0]        PULSE_MIN_RANGE_DEFAULT = 16'h03E8;
  localparam logic [RAW_W-1:0]        PMAX_DEFAULT = 16'h07D0;
  localparam logic signed [CNT_W-1:0] EHL_DEFAULT  = 32'sh0000_4E20;
  localparam logic signed [CNT_W-1:0] ELL_DEFAULT  = -32'sh0000_4E20;
  localparam logic [LPR_W-1:0]        LPR_DEFAULT  = 16'h0064;
  localparam logic signed [CNT_W-1:0] HOME_DEFAULT = 32'sh0000_0000;

endpackage

// ==== verilog/pcel_quad.sv ====
`timescale 1ns/100ps
module pcel_quad
  import pcel_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                ce,
  input  wire logic                enc_a,
  input  wire logic                enc_b,
  input  wire logic                load,
  input  wire logic signed [W-1:0] load_value,
  output logic signed [W-1:0]      count
);

  logic [1:0] a_sync;
  logic [1:0] b_sync;
  logic       a_prev;
  logic       b_prev;

  // one step per edge of either phase gives four counts per line
  wire  a_chg = a_sync[1] ^ a_prev;
  wire  b_chg = b_sync[1] ^ b_prev;
  wire  step  = a_chg ^ b_chg;                  // both moving at once is a glitch, dropped [R13]
  wire  up    = a_sync[1] ^ b_prev;             // a leading b counts up [R16]
  wire  signed [W-1:0] next_count = up ? count + W'(1) : count - W'(1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      a_sync <= 2'h0;
      b_sync <= 2'h0;
      a_prev <= 1'b0;
      b_prev <= 1'b0;
      count  <= '0;
    end else if (ce) begin
      a_sync <= {a_sync[0], enc_a};
      b_sync <= {b_sync[0], enc_b};
      a_prev <= a_sync[1];
      b_prev <= b_sync[1];
      if (load)
        count <= load_value;                    // home load beats a step [R11]
      else if (step)
        count <= next_count;                    // [R13] [R16]
    end
  end

endmodule

// ==== verilog/pcel_top.sv ====
// Behaviour
// R01 - when a converted pulse reaches its minimum the selected input action fires on the selected motors, none by default.
// R02 - motor selection inside an action or usage setting is weight 16 for motor one and 32 for motor two over the base code.
// R03 - pulse mode 0 disables the input, 1 measures width, 2 frequency and 3 period.
// R04 - each enabled pulse input is converted to a signed value from -1000 to +1000.
// R05 - polarity 1 inverts the converted value to run +1000 down to -1000, polarity 0 passes it unchanged.
// R06 - the high-limit action fires when the encoder count rises past the upper boundary, default 20000.
// R07 - the low-limit action fires when the encoder count falls below the lower boundary, default -20000.
// R08 - in relative position mode -1000 maps to the low limit and the two limits span the travel range.
// R09 - the high-limit action setting picks an input action for the upper boundary, default 0 meaning none.
// R10 - the low-limit action setting picks an input action plus motors for the lower boundary, default none.
// R11 - the home value loads the encoder counter on a home switch, host home command or script home request.
// R12 - encoder usage base 0 is unused, 1 command source and 2 feedback, with the motor weights added.
// R13 - the encoder counter advances four counts per encoder line.
// R14 - lines per revolution is accepted from 1 to 5000, default 100.
// R15 - the pulse minimum in microseconds is the -1000 point and captures are bounded at 65000 microseconds.
// R16 - the encoder counter is signed, follows the quadrature phase order, and limits compare signed.
`timescale 1ns/100ps
module pcel_top
  import pcel_pkg::*;
#(
  parameter int unsigned GATE_LEN_US = GATE_US,
  parameter int          CW          = CNT_W
) (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    ce,
  input  wire logic                    pulse_in,
  input  wire logic                    enc_a,
  input  wire logic                    enc_b,
  input  wire logic                    home_switch,
  input  wire logic                    host_home_cmd,
  input  wire logic                    script_home_req,
  input  wire logic [1:0]              pulse_mode_select,
  input  wire logic                    pulse_polarity,
  input  wire logic [RAW_W-1:0]        pulse_min_range,
  input  wire logic [RAW_W-1:0]        pulse_max_range,
  input  wire logic [SET_W-1:0]        pulse_min_action,
  input  wire logic [SET_W-1:0]        enc_usage,
  input  wire logic [LPR_W-1:0]        enc_lines_per_rev,
  input  wire logic signed [CW-1:0]    enc_high_count_limit,
  input  wire logic signed [CW-1:0]    enc_low_count_limit,
  input  wire logic [SET_W-1:0]        enc_high_limit_action,
  input  wire logic [SET_W-1:0]        enc_low_limit_action,
  input  wire logic signed [CW-1:0]    enc_home_load_value,
  input  wire logic signed [VAL_W-1:0] rel_pos_cmd,
  output logic [RAW_W-1:0]             pulse_raw,
  output logic signed [VAL_W-1:0]      pulse_value,
  output logic                         pulse_value_valid,
  output logic                         pulse_min_fire,
  output logic [CODE_W-1:0]            pulse_min_act_code,
  output logic [1:0]                   pulse_min_act_motors,
  output logic signed [CW-1:0]         enc_count,
  output logic                         enc_high_fire,
  output logic [CODE_W-1:0]            enc_high_act_code,
  output logic [1:0]                   enc_high_act_motors,
  output logic                         enc_low_fire,
  output logic [CODE_W-1:0]            enc_low_act_code,
  output logic [1:0]                   enc_low_act_motors,
  output logic                         enc_is_command,
  output logic                         enc_is_feedback,
  output logic [1:0]                   enc_motors,
  output logic [CPR_W-1:0]             enc_counts_per_rev,
  output logic                         enc_lpr_ok,
  output logic signed [CW-1:0]         rel_pos_target
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [CODE_W-1:0] set_code(input logic [SET_W-1:0] s);
    set_code = s[CODE_W-1:0];
  endfunction

  function automatic logic [1:0] set_motors(input logic [SET_W-1:0] s);
    set_motors = {s[SET_MOT2_BIT], s[SET_MOT1_BIT]};                 // [R02]
  endfunction

  // linear map of raw onto -1000..+1000 with min at -1000 and max at +1000
  function automatic logic signed [VAL_W-1:0] scale(input logic [RAW_W-1:0] raw,
                                                    input logic [RAW_W-1:0] lo,
                                                    input logic [RAW_W-1:0] hi);
    logic signed [31:0] diff;
    logic signed [31:0] span;
    logic signed [31:0] v;
    diff = $signed({16'h0000, raw}) - $signed({16'h0000, lo});
    span = $signed({16'h0000, hi}) - $signed({16'h0000, lo});
    if (span <= 0)
      v = (diff <= 0) ? 32'(VAL_LO) : 32'(VAL_HI);
    else
      v = (diff * VAL_SPAN) / span + 32'(VAL_LO);                   // [R04] [R15]
    if (v > 32'(VAL_HI))
      v = 32'(VAL_HI);
    if (v < 32'(VAL_LO))
      v = 32'(VAL_LO);
    scale = v[VAL_W-1:0];
  endfunction

  // relative command -1000..+1000 onto the low..high travel range
  function automatic logic signed [CW-1:0] rel_map(input logic signed [VAL_W-1:0] cmd,
                                                   input logic signed [CW-1:0]    lo,
                                                   input logic signed [CW-1:0]    hi);
    logic signed [63:0] off;
    logic signed [63:0] rng;
    logic signed [63:0] t;
    off = 64'(cmd) - 64'(VAL_LO);
    rng = 64'(hi) - 64'(lo);
    t   = 64'(lo) + (off * rng) / 64'(VAL_SPAN);                    // [R08]
    rel_map = t[CW-1:0];
  endfunction

  function automatic logic [RAW_W-1:0] sat_raw(input logic [31:0] x);
    sat_raw = (x > 32'(RAW_MAX)) ? RAW_MAX : x[RAW_W-1:0];          // [R15]
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pulse capture

  localparam int PRE_W  = $clog2(US_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(US_CYCLES - 1);
  localparam logic [31:0]      GATE_LAST = 32'(GATE_LEN_US - 1);

  logic [2:0]       p_sync;
  logic [PRE_W-1:0] prescale;
  logic [31:0]      us_cnt;
  logic [31:0]      gate_cnt;
  logic [31:0]      edge_cnt;
  logic             raw_new;
  logic             at_min;

  wire p_rise   = p_sync[1] & ~p_sync[2];
  wire p_fall   = ~p_sync[1] & p_sync[2];
  wire us_tick  = (prescale == PRE_LAST);
  wire mode_off = (pulse_mode_select == PMODE_OFF);                    // [R03]
  wire mode_w   = (pulse_mode_select == PMODE_WIDTH);
  wire mode_f   = (pulse_mode_select == PMODE_FREQ);
  wire mode_p   = (pulse_mode_select == PMODE_PERIOD);
  wire gate_end = mode_f & us_tick & (gate_cnt == GATE_LAST);
  wire cap_w    = mode_w & p_fall;                                     // width: rise to fall [R03]
  wire cap_p    = mode_p & p_rise;                                     // period: rise to rise [R03]
  wire capture  = cap_w | cap_p | gate_end;
  wire [RAW_W-1:0] next_raw = gate_end ? sat_raw(edge_cnt) : sat_raw(us_cnt);
  wire us_clear = ((mode_w | mode_p) & p_rise) | mode_off;
  wire [31:0] us_inc = (us_cnt > 32'(RAW_MAX)) ? us_cnt : us_cnt + 32'd1;  // saturates, no wrap

  wire signed [VAL_W-1:0] conv      = scale(pulse_raw, pulse_min_range, pulse_max_range);
  wire signed [VAL_W-1:0] next_val  = pulse_polarity ? -conv : conv;   // [R05]
  wire                    next_min  = (pulse_raw <= pulse_min_range);  // [R15]
  wire [CODE_W-1:0]       pulse_min_range_code = set_code(pulse_min_action);
  wire                    pulse_min_range_go   = raw_new & next_min & ~at_min & (pulse_min_range_code != ACT_NONE);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      p_sync   <= 3'h0;
      prescale <= '0;
      us_cnt   <= '0;
      gate_cnt <= '0;
      edge_cnt <= '0;
      pulse_raw <= '0;
      raw_new  <= 1'b0;
    end else if (ce) begin
      p_sync   <= {p_sync[1:0], pulse_in};
      prescale <= us_tick ? '0 : prescale + PRE_W'(1);
      raw_new  <= capture;
      if (capture)
        pulse_raw <= next_raw;                                         // [R15]
      if (us_clear || gate_end)
        us_cnt <= '0;
      else if (us_tick)
        us_cnt <= us_inc;
      if (!mode_f || gate_end)
        gate_cnt <= '0;
      else if (us_tick)
        gate_cnt <= gate_cnt + 32'd1;
      if (!mode_f || gate_end)
        edge_cnt <= '0;
      else if (p_rise)
        edge_cnt <= edge_cnt + 32'd1;                                  // frequency: edges per gate [R03]
    end
  end

  // a disabled input holds zero and never fires its action
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulse_value          <= '0;
      pulse_value_valid    <= 1'b0;
      at_min               <= 1'b0;
      pulse_min_fire       <= 1'b0;
      pulse_min_act_code   <= ACT_NONE;
      pulse_min_act_motors <= 2'h0;
    end else if (ce) begin
      pulse_value_valid <= raw_new & ~mode_off;
      pulse_min_fire    <= pulse_min_range_go & ~mode_off;                        // [R01]
      if (mode_off) begin
        pulse_value <= '0;
        at_min      <= 1'b0;
      end else if (raw_new) begin
        pulse_value <= next_val;                                       // [R04] [R05]
        at_min      <= next_min;
      end
      if (pulse_min_range_go && !mode_off) begin
        pulse_min_act_code   <= pulse_min_range_code;                             // [R01]
        pulse_min_act_motors <= set_motors(pulse_min_action);          // [R02]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // encoder counter and home

  logic [1:0] h_sync;
  logic       h_prev;

  wire home_edge = h_sync[1] & ~h_prev;
  wire home_load = home_edge | host_home_cmd | script_home_req;        // [R11]

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      h_sync <= 2'h0;
      h_prev <= 1'b0;
    end else if (ce) begin
      h_sync <= {h_sync[0], home_switch};
      h_prev <= h_sync[1];
    end
  end

  pcel_quad #(
    .W (CW)
  ) u_quad (
    .clk        (clk),
    .nrst       (nrst),
    .ce         (ce),
    .enc_a      (enc_a),
    .enc_b      (enc_b),
    .load       (home_load),
    .load_value (enc_home_load_value),
    .count      (enc_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // soft limits

  logic above;
  logic below;

  // fire once on crossing; staying out of range does not refire
  wire next_above = (enc_count > enc_high_count_limit);                // signed compare [R16]
  wire next_below = (enc_count < enc_low_count_limit);                 // [R16]
  wire [CODE_W-1:0] hi_code = set_code(enc_high_limit_action);
  wire [CODE_W-1:0] lo_code = set_code(enc_low_limit_action);
  wire hi_go = next_above & ~above & (hi_code != ACT_NONE);            // [R06] [R09]
  wire lo_go = next_below & ~below & (lo_code != ACT_NONE);            // [R07] [R10]

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      above               <= 1'b0;
      below               <= 1'b0;
      enc_high_fire       <= 1'b0;
      enc_low_fire        <= 1'b0;
      enc_high_act_code   <= ACT_NONE;
      enc_high_act_motors <= 2'h0;
      enc_low_act_code    <= ACT_NONE;
      enc_low_act_motors  <= 2'h0;
    end else if (ce) begin
      above         <= next_above;
      below         <= next_below;
      enc_high_fire <= hi_go;                                          // [R06]
      enc_low_fire  <= lo_go;                                          // [R07]
      if (hi_go) begin
        enc_high_act_code   <= hi_code;                                // [R09]
        enc_high_act_motors <= set_motors(enc_high_limit_action);      // [R02]
      end
      if (lo_go) begin
        enc_low_act_code   <= lo_code;                                 // [R10]
        enc_low_act_motors <= set_motors(enc_low_limit_action);        // [R02] [R10]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // usage, resolution and relative position

  // out-of-range line counts are refused and the last good figure kept
  wire lpr_ok = (enc_lines_per_rev >= LPR_MIN) && (enc_lines_per_rev <= LPR_MAX);  // [R14]
  wire [CODE_W-1:0] use_code = set_code(enc_usage);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      enc_is_command     <= 1'b0;
      enc_is_feedback    <= 1'b0;
      enc_motors         <= 2'h0;
      enc_lpr_ok         <= 1'b0;
      enc_counts_per_rev <= CPR_W'(LPR_DEFAULT) * CPR_W'(COUNTS_LINE);
      rel_pos_target     <= '0;
    end else if (ce) begin
      enc_is_command  <= (use_code == EUSE_COMMAND);                   // [R12]
      enc_is_feedback <= (use_code == EUSE_FEEDBACK);                  // [R12]
      enc_motors      <= (use_code == EUSE_UNUSED) ? 2'h0 : set_motors(enc_usage);  // [R12] [R02]
      enc_lpr_ok      <= lpr_ok;
      if (lpr_ok)
        enc_counts_per_rev <= CPR_W'(enc_lines_per_rev) * CPR_W'(COUNTS_LINE);     // [R13] [R14]
      rel_pos_target  <= rel_map(rel_pos_cmd, enc_low_count_limit, enc_high_count_limit);  // [R08]
    end
  end

endmodule

// ==== tb/pcel_assertions.sv ====
`timescale 1ns/100ps
module pcel_chk
  import pcel_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire logic                    ce,
  input wire logic                    host_home_cmd,
  input wire logic                    script_home_req,
  input wire logic [1:0]              pulse_mode_select,
  input wire logic                    pulse_polarity,
  input wire logic [SET_W-1:0]        enc_high_limit_action,
  input wire logic [SET_W-1:0]        enc_low_limit_action,
  input wire logic [SET_W-1:0]        enc_usage,
  input wire logic [LPR_W-1:0]        enc_lines_per_rev,
  input wire logic signed [CW-1:0]    enc_high_count_limit,
  input wire logic signed [CW-1:0]    enc_low_count_limit,
  input wire logic signed [CW-1:0]    enc_home_load_value,
  input wire logic signed [VAL_W-1:0] rel_pos_cmd,
  input wire logic signed [VAL_W-1:0] pulse_value,
  input wire logic                    pulse_value_valid,
  input wire logic                    pulse_min_fire,
  input wire logic signed [CW-1:0]    enc_count,
  input wire logic                    enc_high_fire,
  input wire logic [CODE_W-1:0]       enc_high_act_code,
  input wire logic [1:0]              enc_high_act_motors,
  input wire logic                    enc_low_fire,
  input wire logic [CODE_W-1:0]       enc_low_act_code,
  input wire logic [1:0]              enc_low_act_motors,
  input wire logic                    enc_is_feedback,
  input wire logic [CPR_W-1:0]        enc_counts_per_rev,
  input wire logic signed [CW-1:0]    rel_pos_target
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  AST_HOST_HOME:
  assert property (ce && host_home_cmd |=> enc_count == $past(enc_home_load_value)) else $error("host home missed");
  AST_SCRIPT_HOME:
  assert property (ce && script_home_req |=> enc_count == $past(enc_home_load_value)) else $error("script home missed");
  // entry only: a count parked past the limit must not keep firing
  AST_HIGH_ENTRY:
  assert property (ce && enc_high_limit_action[3:0] != ACT_NONE && enc_count > enc_high_count_limit
    && $past(enc_count) <= enc_high_count_limit |=> enc_high_fire) else $error("high limit fire missed");
  AST_HIGH_CAUSE:
  assert property (enc_high_fire |-> $past(enc_count) > $past(enc_high_count_limit)
    && {enc_high_act_motors, enc_high_act_code} == $past(enc_high_limit_action[5:0])) else $error("bad high fire");
  AST_LOW_ENTRY:
  assert property (ce && enc_low_limit_action[3:0] != ACT_NONE && enc_count < enc_low_count_limit
    && $past(enc_count) >= enc_low_count_limit |=> enc_low_fire) else $error("low limit fire missed");
  AST_LOW_CAUSE:
  assert property (enc_low_fire |-> $past(enc_count) < $past(enc_low_count_limit)
    && {enc_low_act_motors, enc_low_act_code} == $past(enc_low_limit_action[5:0])) else $error("bad low fire");
  AST_CPR:
  assert property (ce && enc_lines_per_rev >= LPR_MIN && enc_lines_per_rev <= LPR_MAX
    |=> enc_counts_per_rev == CPR_W'(COUNTS_LINE * $past(enc_lines_per_rev))) else $error("bad counts per rev");
  AST_REL_LOW:
  assert property (ce && rel_pos_cmd == VAL_LO |=> rel_pos_target == $past(enc_low_count_limit)) else $error("bad rel low");
  AST_USAGE:
  assert property (ce |=> enc_is_feedback == ($past(enc_usage[3:0]) == EUSE_FEEDBACK)) else $error("bad usage");
  AST_MODE_OFF:
  assert property ((pulse_mode_select == PMODE_OFF)[*4] |-> !pulse_value_valid && !pulse_min_fire && pulse_value == 0)
    else $error("pulse active while off");
  AST_MIN_VALUE:
  assert property (pulse_min_fire |-> pulse_value_valid && pulse_value == (pulse_polarity ? VAL_HI : VAL_LO))
    else $error("bad min fire");
  AST_RANGE:
  assert property (pulse_value_valid |-> pulse_value >= VAL_LO && pulse_value <= VAL_HI) else $error("value out of span");
  COV_HIGH: cover property (enc_high_fire);
  COV_LOW: cover property (enc_low_fire);
  COV_MIN: cover property (pulse_min_fire && pulse_polarity);
endmodule

bind pcel_top pcel_chk #(.CW(CW)) chk_u (.*);

// ==== tb/pcel_source.sv ====
`timescale 1ns/100ps
module pcel_source
  import pcel_pkg::*;
(
  input  wire logic clk,
  output logic      enc_a,
  output logic      enc_b,
  output logic      pulse_in
);
  logic [1:0] ph = 2'h0;
  initial begin
    enc_a = 1'b0;
    enc_b = 1'b0;
    pulse_in = 1'b0;
  end
  // up runs 00,10,11,01; four-cycle hold outlasts the two-stage input sync
  task automatic lines(input int n, input bit up);
    for (int i = 0; i < 4 * n; i++) begin
      repeat (4) @(posedge clk);
      #1;
      ph = up ? ph + 2'h1 : ph - 2'h1;
      enc_a = ^ph;
      enc_b = ph[1];
    end
  endtask
  task automatic pulse(input int w_us, input int gap_us);
    @(posedge clk);
    #1;
    pulse_in = 1'b1;
    repeat (w_us * US_CYCLES) @(posedge clk);
    #1;
    pulse_in = 1'b0;
    repeat (gap_us * US_CYCLES) @(posedge clk);
    #1;
  endtask
endmodule

// ==== tb/pulse_capture_encoder_limits_tb.sv ====
`timescale 1ns/100ps
module pulse_capture_encoder_limits_tb;
  import pcel_pkg::*;
  localparam int CW = CNT_W;
  localparam int MN = 10;
  localparam int MX = 30;
  logic                    clk = 1'b0, nrst = 1'b0, ce = 1'b1, pulse_polarity = 1'b0;
  logic                    home_switch = 1'b0, host_home_cmd = 1'b0, script_home_req = 1'b0;
  logic [1:0]              pulse_mode_select = PMODE_WIDTH;
  logic [RAW_W-1:0]        pulse_min_range = 16'h000A, pulse_max_range = 16'h001E;
  logic [SET_W-1:0]        pulse_min_action = 8'h13, enc_usage = 8'h00;
  logic [SET_W-1:0]        enc_high_limit_action = 8'h13, enc_low_limit_action = 8'h25;
  logic [LPR_W-1:0]        enc_lines_per_rev = LPR_DEFAULT;
  logic signed [CW-1:0]    enc_high_count_limit = EHL_DEFAULT, enc_low_count_limit = ELL_DEFAULT;
  logic signed [CW-1:0]    enc_home_load_value = HOME_DEFAULT, enc_count, rel_pos_target;
  logic signed [VAL_W-1:0] rel_pos_cmd = 12'sh000, pulse_value, last_val;
  logic                    enc_a, enc_b, pulse_in, pulse_value_valid, pulse_min_fire, enc_high_fire;
  logic                    enc_low_fire, enc_is_command, enc_is_feedback, enc_lpr_ok;
  logic [RAW_W-1:0]        pulse_raw;
  logic [CODE_W-1:0]       pulse_min_act_code, enc_high_act_code, enc_low_act_code;
  logic [1:0]              pulse_min_act_motors, enc_high_act_motors, enc_low_act_motors, enc_motors;
  logic [CPR_W-1:0]        enc_counts_per_rev;
  logic [SET_W-1:0]        use_tab[4] = '{8'h30, 8'h11, 8'h22, 8'h31};
  logic [LPR_W-1:0]        lpr_tab[5] = '{16'h00C8, 16'h0000, 16'h1388, 16'h1389, 16'h0001};
  logic [CPR_W-1:0]        cpr_tab[5] = '{18'h0_0320, 18'h0_0320, 18'h0_4E20, 18'h0_4E20, 18'h0_0004};
  logic [4:0]              ok_bits = 5'h15;
  int                      mismatches = 0, checked = 0, cycles = 0, nvalid = 0, nfire = 0, nhi = 0, nlo = 0, n0;
  ////////////////////////////////////////////////////////////////////////////
  pcel_top #(.GATE_LEN_US(10)) dut_u (
    .clk, .nrst, .ce, .pulse_in, .enc_a, .enc_b, .home_switch, .host_home_cmd, .script_home_req,
    .pulse_mode_select, .pulse_polarity, .pulse_min_range, .pulse_max_range, .pulse_min_action, .enc_usage,
    .enc_lines_per_rev, .enc_high_count_limit, .enc_low_count_limit, .enc_high_limit_action,
    .enc_low_limit_action, .enc_home_load_value, .rel_pos_cmd, .pulse_raw, .pulse_value, .pulse_value_valid,
    .pulse_min_fire, .pulse_min_act_code, .pulse_min_act_motors, .enc_count, .enc_high_fire, .enc_high_act_code,
    .enc_high_act_motors, .enc_low_fire, .enc_low_act_code, .enc_low_act_motors, .enc_is_command,
    .enc_is_feedback, .enc_motors, .enc_counts_per_rev, .enc_lpr_ok, .rel_pos_target
  );
  pcel_source src_u (.clk, .enc_a, .enc_b, .pulse_in);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (pulse_value_valid === 1'b1) begin
      nvalid++;
      last_val = pulse_value;
    end
    nfire += int'(pulse_min_fire === 1'b1);
    nhi += int'(enc_high_fire === 1'b1);
    nlo += int'(enc_low_fire === 1'b1);
    if (cycles == 60000) begin
      mismatches++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp(input logic [CW-1:0] got, input logic [CW-1:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  function automatic int scale(input int raw, input bit inv);
    int v;
    v = raw <= MN ? -1000 : raw >= MX ? 1000 : -1000 + (raw - MN) * 2000 / (MX - MN);
    return inv ? -v : v;
  endfunction
  task automatic pw(input int w, input int df);
    int f;
    f = nfire;
    src_u.pulse(w, 5);
    cmp(pulse_raw, w);
    cmp(last_val, scale(w, pulse_polarity));
    cmp(nfire - f, df);
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(2);
    cmp(enc_counts_per_rev, 18'h0_0190);
    cmp(enc_count, 0);
    tick(10);
    nrst = 1'b1;
    tick(2);
    pw(10, 1);
    cmp({pulse_min_act_motors, pulse_min_act_code}, 6'h13);
    pw(10, 0);
    pw(15, 0);
    pulse_polarity = 1'b1;
    pw(30, 0);
    pw(10, 1);
    pulse_polarity = 1'b0;
    pulse_min_action = 8'h00;
    pw(20, 0);
    pw(10, 0);
    pulse_mode_select = PMODE_OFF;
    n0 = nvalid;
    src_u.pulse(20, 5);
    cmp(nvalid - n0, 0);
    cmp(pulse_value, 0);
    pulse_mode_select = PMODE_PERIOD;
    repeat (3) src_u.pulse(5, 15);
    cmp(pulse_raw, 20);
    cmp(last_val, scale(20, 0));
    // at most five edges fit one gate, all at or under the minimum
    pulse_mode_select = PMODE_FREQ;
    n0 = nvalid;
    repeat (15) src_u.pulse(1, 1);
    cmp(nvalid > n0, 1);
    cmp(last_val, VAL_LO);
    enc_home_load_value = 32'sh0000_0064;
    host_home_cmd = 1'b1;
    tick(1);
    host_home_cmd = 1'b0;
    cmp(enc_count, 32'sh0000_0064);
    enc_home_load_value = -32'sh0000_0005;
    script_home_req = 1'b1;
    tick(1);
    script_home_req = 1'b0;
    cmp(enc_count, -32'sh0000_0005);
    enc_home_load_value = HOME_DEFAULT;
    home_switch = 1'b1;
    tick(6);
    home_switch = 1'b0;
    cmp(enc_count, 0);
    enc_high_count_limit = 32'sh0000_0008;
    enc_low_count_limit = -32'sh0000_0008;
    n0 = nhi;
    src_u.lines(3, 1);
    tick(5);
    cmp(enc_count, 32'sh0000_000C);
    cmp(nhi - n0, 1);
    cmp({enc_high_act_motors, enc_high_act_code}, 6'h13);
    n0 = nlo;
    src_u.lines(6, 0);
    tick(5);
    cmp(enc_count, -32'sh0000_000C);
    cmp(nlo - n0, 1);
    cmp({enc_low_act_motors, enc_low_act_code}, 6'h25);
    rel_pos_cmd = VAL_LO;
    tick(1);
    cmp(rel_pos_target, -32'sh0000_0008);
    rel_pos_cmd = VAL_HI;
    tick(1);
    cmp(rel_pos_target, 32'sh0000_0008);
    enc_high_count_limit = EHL_DEFAULT;
    enc_low_count_limit = ELL_DEFAULT;
    rel_pos_cmd = 12'sh1F4;
    tick(2);
    cmp(rel_pos_target, 32'sh0000_2710);
    foreach (use_tab[i]) begin
      enc_usage = use_tab[i];
      tick(2);
      cmp({enc_is_command, enc_is_feedback, enc_motors}, {use_tab[i][3:0] == 4'h1, use_tab[i][3:0] == 4'h2,
        use_tab[i][3:0] == 4'h0 ? 2'b00 : use_tab[i][5:4]});
    end
    foreach (lpr_tab[i]) begin
      enc_lines_per_rev = lpr_tab[i];
      tick(2);
      cmp({enc_lpr_ok, enc_counts_per_rev}, {ok_bits[i], cpr_tab[i]});
    end
    stop_test();
  end
endmodule
